// ==== sst_monitor.v ====
// Second safe-stop transition monitor: selection, supervision, errors, handover.
`include "sst_defs.vh"

// Overview of operation
// - Drive variant: ignore commands, internal halt decelerates
// - Envelope exceeded raises deceleration error, F7/F8 code
// - After error keep braking per error reaction
// - Publish currently effective velocity monitoring limit
// - Optional limitation clamps command to active threshold
// - Time transition against limit, raise timeout error
// - F8 codes only in drive variant, escalated
// - After error, standstill by limit plus tolerance
// - No tolerance with torque disable or direct escalation
// - Drive variant: envelope acknowledge selects operating stop
// - Trend variant uses trend form of envelope monitor
// - Actual variant uses actual-velocity envelope form
// - NC variants: standstill and time over select stop
// - Done flag edge valid after 10 ms low
// - Early done above target velocity raises F7052
// - NC variants: valid done edge ends transition immediately
// - Accept only with stop configured, inactive, no others
// - Leave on stop one, torque off, deselect, error
module sst_monitor #(
  parameter VW     = 16,
  parameter TW     = 16,
  parameter MS_CYC = `SST_MS_CYC
) (
  input  wire          core_clk_i,
  input  wire          rst_n_i,
  input  wire          stop_sel_i,
  input  wire [1:0]    variant_cfg_i,
  input  wire          sos_configured_i,
  input  wire          sos_active_i,
  input  wire          ss1_active_i,
  input  wire          sto_active_i,
  input  wire          from_safe_state_i,
  input  wire [TW-1:0] t_normal_ms_i,
  input  wire [TW-1:0] t_between_ms_i,
  input  wire [TW-1:0] tol_ms_i,
  input  wire          react_f7_torque_off_i,
  input  wire          f3_eq_f7_i,
  input  wire          env_exceeded_i,
  input  wire          env_ok_ack_i,
  input  wire          nc_done_i,
  input  wire [VW-1:0] act_vel_i,
  input  wire [VW-1:0] standstill_thr_i,
  input  wire [VW-1:0] active_vel_thr_i,
  input  wire [VW-1:0] target_vel_i,
  input  wire [VW-1:0] vel_cmd_i,
  input  wire          limit_en_i,
  output wire          active_o,
  output wire          halt_o,
  output wire [VW-1:0] vel_cmd_o,
  output wire [VW-1:0] vel_limit_o,
  output wire          env_trend_o,
  output wire          env_actual_o,
  output wire          err_decel_o,
  output wire          err_timeout_o,
  output wire          err_target_o,
  output wire [19:0]   err_code_o,
  output wire          brake_o,
  output wire          torque_off_req_o,
  output wire          sos_sel_o,
  output wire          cfg_err_o
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RUN  = 2'h1;
  localparam [1:0] ST_ERR  = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;
  localparam [23:0] MS_LAST = MS_CYC - 1;
  localparam [3:0]  LOW_MS  = `SST_DONE_LOW_MS;

  function [19:0] pick_code;
    input        esc;
    input [19:0] f7;
    input [19:0] f8;
    begin
      pick_code = esc ? f8 : f7;
    end
  endfunction

  reg  [1:0]    state_q;
  reg  [1:0]    state_d;
  reg  [1:0]    var_q;
  reg  [TW-1:0] limit_q;
  reg  [TW-1:0] elapsed_q;
  reg  [TW:0]   err_ms_q;
  reg  [TW:0]   deadline_q;
  reg  [23:0]   pre_q;
  reg           done_s1_q;
  reg           done_s2_q;
  reg           done_d_q;
  reg  [3:0]    low_ms_q;
  reg           halt_q;
  reg  [VW-1:0] cmd_q;
  reg  [VW-1:0] vlim_q;
  reg           trend_q;
  reg           actual_q;
  reg           e_decel_q;
  reg           e_time_q;
  reg           e_tgt_q;
  reg  [19:0]   code_q;
  reg           tor_q;
  reg           cfg_err_q;
  reg           run_q;
  reg           err_q;
  reg           sos_q;

  wire tick       = (pre_q == MS_LAST);
  wire standstill = (act_vel_i < standstill_thr_i);
  wire leave      = !stop_sel_i || ss1_active_i || sto_active_i;
  wire var_ok     = (variant_cfg_i != 2'h3);
  wire drive_var  = (var_q == `SST_VAR_DRIVE);
  wire escalate   = drive_var && f3_eq_f7_i;
  wire time_over  = (elapsed_q >= limit_q);
  // A rising edge only counts after the flag has rested low long enough,
  // so a stuck or chattering flag cannot cut a transition short. One tick
  // more than the low time is asked for, as the first tick after the fall
  // may come at once.
  wire done_edge  = done_s2_q && !done_d_q && (low_ms_q > LOW_MS);
  wire no_tol     = react_f7_torque_off_i || f3_eq_f7_i;
  wire nc_end     = done_edge && !drive_var;
  wire accept     = stop_sel_i && var_ok && sos_configured_i && !sos_active_i &&
                    !ss1_active_i && !sto_active_i;

  // ****************************************************************
  // Synchroniser and done-flag low time
  // ****************************************************************
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_d_q  <= 1'b0;
      low_ms_q  <= 4'h0;
      pre_q     <= 24'h000000;
    end else begin
      done_s1_q <= nc_done_i;
      done_s2_q <= done_s1_q;
      done_d_q  <= done_s2_q;
      pre_q     <= tick ? 24'h000000 : pre_q + 24'h000001;
      if (done_s2_q) begin
        low_ms_q <= 4'h0;
      end else if (tick && (low_ms_q <= LOW_MS)) begin
        low_ms_q <= low_ms_q + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Transition state machine
  // ****************************************************************
  // The next state is decoded apart so that the state flags can be
  // registered with the state and still leave the module as plain flops.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (leave) begin
          state_d = ST_IDLE;
        end else if (env_exceeded_i) begin
          state_d = ST_ERR;
        end else if (nc_end) begin
          state_d = (act_vel_i > target_vel_i) ? ST_ERR : ST_DONE;
        end else if (drive_var && env_ok_ack_i) begin
          state_d = ST_DONE;
        end else if (!drive_var && standstill && time_over) begin
          state_d = ST_DONE;
        end else if (time_over) begin
          state_d = ST_ERR;
        end
      end
      ST_ERR: begin
        // The error state holds until the stop is deselected at standstill; error flags clear on the next accept.
        if (!stop_sel_i && standstill) begin
          state_d = ST_IDLE;
        end
      end
      ST_DONE: begin
        if (leave) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q    <= ST_IDLE;
      var_q      <= `SST_RST_VAR;
      limit_q    <= {TW{1'b0}};
      elapsed_q  <= {TW{1'b0}};
      err_ms_q   <= {(TW+1){1'b0}};
      deadline_q <= {(TW+1){1'b0}};
      e_decel_q  <= 1'b0;
      e_time_q   <= 1'b0;
      e_tgt_q    <= 1'b0;
      code_q     <= `SST_CODE_NONE;
      tor_q      <= 1'b0;
      cfg_err_q  <= 1'b0;
      run_q      <= 1'b0;
      err_q      <= 1'b0;
      sos_q      <= 1'b0;
    end else begin
      state_q   <= state_d;
      run_q     <= (state_d == ST_RUN);
      err_q     <= (state_d == ST_ERR);
      sos_q     <= (state_d == ST_DONE);
      cfg_err_q <= stop_sel_i && !var_ok;
      case (state_q)
        ST_IDLE: begin
          tor_q <= 1'b0;
          if (accept) begin
            var_q     <= variant_cfg_i;
            limit_q   <= from_safe_state_i ? t_between_ms_i : t_normal_ms_i;
            elapsed_q <= {TW{1'b0}};
            e_decel_q <= 1'b0;
            e_time_q  <= 1'b0;
            e_tgt_q   <= 1'b0;
            code_q    <= `SST_CODE_NONE;
          end
        end
        ST_RUN: begin
          if (tick && !time_over) begin
            elapsed_q <= elapsed_q + {{(TW-1){1'b0}}, 1'b1};
          end
          // Base of the post-error deadline is the selected limit, normal or between-stops.
          deadline_q <= no_tol ? {1'b0, limit_q} :
                        {1'b0, limit_q} + {1'b0, tol_ms_i};
          err_ms_q   <= {1'b0, elapsed_q};
          if (!leave && env_exceeded_i) begin
            e_decel_q <= 1'b1;
            code_q    <= pick_code(escalate, `SST_F7_DECEL, `SST_F8_DECEL);
          end else if (!leave && nc_end && (act_vel_i > target_vel_i)) begin
            e_tgt_q <= 1'b1;
            code_q  <= `SST_F7_TARGET;
          end else if (state_d == ST_ERR) begin
            e_time_q <= 1'b1;
            code_q   <= pick_code(escalate, `SST_F7_TIMEOUT, `SST_F8_TIMEOUT);
          end
        end
        ST_ERR: begin
          if (tick && (err_ms_q < deadline_q)) begin
            err_ms_q <= err_ms_q + {{TW{1'b0}}, 1'b1};
          end
          if (!standstill && (err_ms_q >= deadline_q)) begin
            tor_q <= 1'b1;
          end
        end
        default: begin
          tor_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Command path and published limit
  // ****************************************************************
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halt_q   <= 1'b0;
      cmd_q    <= {VW{1'b0}};
      vlim_q   <= {VW{1'b0}};
      trend_q  <= 1'b0;
      actual_q <= 1'b0;
    end else begin
      // The halt is kept through an error so braking never stops half way.
      halt_q   <= ((state_q == ST_RUN) && drive_var) || (state_q == ST_ERR);
      vlim_q   <= active_vel_thr_i;
      trend_q  <= (state_q == ST_RUN) && (var_q == `SST_VAR_TREND);
      actual_q <= (state_q == ST_RUN) && (var_q != `SST_VAR_TREND);
      if (halt_q) begin
        cmd_q <= {VW{1'b0}};
      end else if (limit_en_i && (vel_cmd_i > active_vel_thr_i)) begin
        cmd_q <= active_vel_thr_i;
      end else begin
        cmd_q <= vel_cmd_i;
      end
    end
  end

  assign active_o         = run_q;
  assign halt_o           = halt_q;
  assign vel_cmd_o        = cmd_q;
  assign vel_limit_o      = vlim_q;
  assign env_trend_o      = trend_q;
  assign env_actual_o     = actual_q;
  assign err_decel_o      = e_decel_q;
  assign err_timeout_o    = e_time_q;
  assign err_target_o     = e_tgt_q;
  assign err_code_o       = code_q;
  assign brake_o          = err_q;
  assign torque_off_req_o = tor_q;
  assign sos_sel_o        = sos_q;
  assign cfg_err_o        = cfg_err_q;

endmodule // sst_monitor

// ==== sst_defs.vh ====
// Constants shared by the second safe-stop transition monitor.
`ifndef SST_DEFS_VH
`define SST_DEFS_VH
// ****************************************************************
// Clock and timing
// ****************************************************************
`define SST_CLK_HZ        10000000
`define SST_MS_PER_S      1000
`define SST_MS_CYC        (`SST_CLK_HZ / `SST_MS_PER_S)
`define SST_DONE_LOW_MS   10
// ****************************************************************
// Monitoring variants
// ****************************************************************
`define SST_VAR_DRIVE     2'h0
`define SST_VAR_TREND     2'h1
`define SST_VAR_ACTUAL    2'h2
// ****************************************************************
// Error codes, five hex digits as displayed
// ****************************************************************
`define SST_CODE_NONE     20'h00000
`define SST_F7_TIMEOUT    20'hf7050
`define SST_F7_DECEL      20'hf7051
`define SST_F7_TARGET     20'hf7052
`define SST_F8_TIMEOUT    20'hf8350
`define SST_F8_DECEL      20'hf8351
// ****************************************************************
// Reset values
// ****************************************************************
`define SST_RST_VAR       2'h0
`endif

// ==== sst_ctrl_model.sv ====
// Behavioural motion controller that ramps the axis down and signals done.
module sst_ctrl_model #(
  parameter LOW_CYC = 120
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        go_i,
  output logic      [15:0] vel_o,
  output logic             done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int low_q;
  // Done waits out a long low phase so that the monitor sees a valid edge.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vel_o  <= 16'h00c8;
      low_q  <= 0;
      done_o <= 1'b0;
    end else begin
      low_q <= done_o ? 0 : low_q + 1;
      if (!go_i) begin
        vel_o  <= 16'h00c8;
        done_o <= 1'b0;
      end else begin
        vel_o  <= (vel_o > 16'h0002) ? vel_o - 16'h0002 : 16'h0000;
        done_o <= done_o | (vel_o == 16'h0000 && low_q >= LOW_CYC);
      end
    end
  end
endmodule // sst_ctrl_model

// ==== sst_monitor_properties.sv ====
// Concurrent checks on the ports of the second safe-stop monitor.
`include "sst_defs.vh"
module sst_monitor_props #(
  parameter VW = 16
) (
  input wire          core_clk_i,
  input wire          rst_n_i,
  input wire          stop_sel_i,
  input wire [1:0]    variant_cfg_i,
  input wire          sos_configured_i,
  input wire          sos_active_i,
  input wire          ss1_active_i,
  input wire          sto_active_i,
  input wire          f3_eq_f7_i,
  input wire          env_exceeded_i,
  input wire          env_ok_ack_i,
  input wire          limit_en_i,
  input wire [VW-1:0] active_vel_thr_i,
  input wire          active_o,
  input wire          halt_o,
  input wire [VW-1:0] vel_cmd_o,
  input wire [VW-1:0] vel_limit_o,
  input wire          env_trend_o,
  input wire          env_actual_o,
  input wire          err_decel_o,
  input wire [19:0]   err_code_o,
  input wire          brake_o,
  input wire          sos_sel_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_run_ok;
    active_o && stop_sel_i && !ss1_active_i && !sto_active_i;
  endsequence
  sequence s_idle_ok;
    !active_o && !sos_sel_o && !brake_o && stop_sel_i && variant_cfg_i != 2'h3
      && sos_configured_i && !sos_active_i && !ss1_active_i && !sto_active_i;
  endsequence
  accept_stop_a: assert property (s_idle_ok |=> active_o)
    else $error("stop request not taken");
  leave_run_a: assert property (active_o && !stop_sel_i |=> !active_o)
    else $error("transition not left");
  decel_err_a: assert property (s_run_ok ##0 env_exceeded_i |=> err_decel_o && brake_o)
    else $error("decel error missing");
  decel_code_a: assert property ($rose(err_decel_o) |-> err_code_o ==
    (($past(f3_eq_f7_i) && $past(variant_cfg_i) == 2'h0) ? `SST_F8_DECEL : `SST_F7_DECEL))
    else $error("decel code wrong");
  drive_done_a: assert property (s_run_ok ##0 variant_cfg_i == 2'h0 && env_ok_ack_i
    && !env_exceeded_i |=> sos_sel_o && !active_o) else $error("handover missing");
  halt_drive_a: assert property (s_run_ok ##0 variant_cfg_i == 2'h0 |=> halt_o)
    else $error("internal halt missing");
  env_form_a: assert property (s_run_ok |=> env_trend_o != env_actual_o
    && env_trend_o == ($past(variant_cfg_i) == 2'h1)) else $error("envelope form wrong");
  limit_pub_a: assert property ($past(rst_n_i) |-> vel_limit_o == $past(active_vel_thr_i))
    else $error("published limit stale");
  clamp_a: assert property ($past(rst_n_i) && $past(limit_en_i) && !halt_o && !$past(halt_o)
    |-> vel_cmd_o <= $past(active_vel_thr_i)) else $error("command not clamped");
endmodule // sst_monitor_props
bind sst_monitor sst_monitor_props #(.VW(VW)) u_props (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .stop_sel_i(stop_sel_i), .variant_cfg_i(variant_cfg_i),
  .sos_configured_i(sos_configured_i), .sos_active_i(sos_active_i), .ss1_active_i(ss1_active_i),
  .sto_active_i(sto_active_i), .f3_eq_f7_i(f3_eq_f7_i), .env_exceeded_i(env_exceeded_i),
  .env_ok_ack_i(env_ok_ack_i), .limit_en_i(limit_en_i), .active_vel_thr_i(active_vel_thr_i),
  .active_o(active_o), .halt_o(halt_o), .vel_cmd_o(vel_cmd_o), .vel_limit_o(vel_limit_o),
  .env_trend_o(env_trend_o), .env_actual_o(env_actual_o), .err_decel_o(err_decel_o),
  .err_code_o(err_code_o), .brake_o(brake_o), .sos_sel_o(sos_sel_o));

// ==== testbench.sv ====
// Self-checking bench for the second safe-stop transition monitor.
`include "sst_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, sel = 0, sos_cfg = 1, sos_act = 0, ss1 = 0, torque_off_state = 0, fsafe = 0;
  logic react = 0, f3 = 0, env_x = 0, ack = 0, tb_done = 0, go = 0, use_m = 0, lim_en = 1;
  logic [1:0]  var_q = 2'h0;
  logic [15:0] vel = 0, thr = 0, cmd = 0, tol = 16'h0003, m_vel, cmd_o, lim_o;
  wire  [15:0] vcmd = use_m ? m_vel : cmd;
  logic        m_done, active, halt, trend, actual, e_dec, e_to, e_tgt, brake, toff, safe_operating_stop_state, cfg_e;
  logic [19:0] code;
  int          seed = 95, error_cnt = 0, tests_run = 0, n, w;
  int          lim_exp[$], cmd_exp[$];
  always #50 clk = ~clk;
  always @(negedge clk) begin
    cmd <= 16'($random(seed));
    thr <= 16'($random(seed));
  end
  sst_ctrl_model i_sst_ctrl_model (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .vel_o(m_vel),
    .done_o(m_done));
  sst_monitor #(.MS_CYC(10)) i_sst_monitor (.core_clk_i(clk), .rst_n_i(rst_n), .stop_sel_i(sel),
    .variant_cfg_i(var_q), .sos_configured_i(sos_cfg), .sos_active_i(sos_act),
    .ss1_active_i(ss1), .sto_active_i(torque_off_state), .from_safe_state_i(fsafe),
    .t_normal_ms_i(16'h0014), .t_between_ms_i(16'h0005), .tol_ms_i(tol),
    .react_f7_torque_off_i(react), .f3_eq_f7_i(f3), .env_exceeded_i(env_x), .env_ok_ack_i(ack),
    .nc_done_i(m_done | tb_done), .act_vel_i(use_m ? m_vel : vel), .standstill_thr_i(16'h0004),
    .active_vel_thr_i(thr), .target_vel_i(16'h000a), .vel_cmd_i(vcmd),
    .limit_en_i(lim_en), .active_o(active), .halt_o(halt), .vel_cmd_o(cmd_o),
    .vel_limit_o(lim_o), .env_trend_o(trend), .env_actual_o(actual), .err_decel_o(e_dec),
    .err_timeout_o(e_to), .err_target_o(e_tgt), .err_code_o(code), .brake_o(brake),
    .torque_off_req_o(toff), .sos_sel_o(safe_operating_stop_state), .cfg_err_o(cfg_e));
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task chk_b(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task chk_c(input logic [19:0] g, input logic [19:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t value %h expected %h", $time, g, e);
    end
  endtask
  // Reference for the published limit and the forwarded command, one cycle behind.
  always @(posedge clk) begin
    if (rst_n) begin
      lim_exp.push_back(int'(thr));
      if (halt) cmd_exp.push_back(0);
      else if (lim_en && vcmd > thr) cmd_exp.push_back(int'(thr));
      else cmd_exp.push_back(int'(vcmd));
    end
  end
  always @(negedge clk) begin
    if (lim_exp.size() > 0) begin
      chk_c({4'h0, lim_o}, 20'(lim_exp.pop_front()));
      chk_c({4'h0, cmd_o}, 20'(cmd_exp.pop_front()));
    end
  end
  task start(input logic [1:0] v);
    var_q = v;
    sel = 1;
    cyc(2);
  endtask
  // Axis at rest and request gone, so an error state can also be left.
  task finish_stop;
    {sel, env_x, ack, go, use_m, tb_done, ss1} = 0;
    vel = 0;
    cyc(4);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    close_out;
  end
  initial begin
    cyc(6);
    rst_n = 1;
    for (n = 0; n < 4; n++) begin
      {torque_off_state, ss1, sos_act, sos_cfg} = 4'(4'h1 << n) ^ 4'h1;
      start(2'h0);
      chk_b(active, 1'b0);
      finish_stop;
    end
    {torque_off_state, sos_cfg} = 2'b01;
    start(2'h3);
    chk_b(cfg_e, 1'b1);
    chk_b(active, 1'b0);
    start(2'h0);
    chk_b(active, 1'b1);
    cyc(1);
    chk_b(halt, 1'b1);
    cyc(1);
    chk_c({4'h0, cmd_o}, 20'h0);
    ack = 1;
    cyc(1);
    chk_b(safe_operating_stop_state, 1'b1);
    finish_stop;
    start(2'h1);
    ss1 = 1;
    cyc(1);
    chk_b(active, 1'b0);
    finish_stop;
    for (n = 0; n < 6; n++) begin
      f3 = n[0];
      lim_en = n[1];
      start(2'(n >> 1));
      chk_b(trend, (n >> 1) == 1);
      chk_b(actual, (n >> 1) != 1);
      env_x = 1;
      cyc(1);
      chk_b(e_dec, 1'b1);
      chk_b(brake, 1'b1);
      chk_c(code, (f3 && n < 2) ? `SST_F8_DECEL : `SST_F7_DECEL);
      finish_stop;
    end
    fsafe = 1;
    for (n = 0; n < 3; n++) begin
      react = (n == 1);
      f3 = (n == 2);
      vel = 16'h0040;
      start(2'h1);
      cyc(35);
      chk_b(e_to, 1'b0);
      for (w = 0; w < 40 && e_to !== 1'b1; w++) cyc(1);
      chk_b(e_to, 1'b1);
      chk_c(code, `SST_F7_TIMEOUT);
      cyc(15);
      chk_b(toff, n != 0);
      finish_stop;
    end
    start(2'h1);
    cyc(30);
    chk_b(safe_operating_stop_state, 1'b0);
    cyc(40);
    chk_b(safe_operating_stop_state, 1'b1);
    finish_stop;
    fsafe = 0;
    use_m = 1;
    go = 1;
    start(2'h2);
    for (w = 0; w < 180 && safe_operating_stop_state !== 1'b1; w++) cyc(1);
    chk_b(safe_operating_stop_state, 1'b1);
    chk_b(e_tgt, 1'b0);
    finish_stop;
    vel = 16'h0032;
    start(2'h2);
    tb_done = 1;
    cyc(6);
    chk_b(e_tgt, 1'b0);
    tb_done = 0;
    cyc(120);
    tb_done = 1;
    cyc(6);
    chk_b(e_tgt, 1'b1);
    chk_c(code, `SST_F7_TARGET);
    finish_stop;
    close_out;
  end
endmodule // testbench
